// [hw/sic_top.sv]
// sic_top: light and deep idle sequencer with apb registers
// assumes pins and reset sources are asynchronous to mclk;
// the interrupt controller inputs run on mclk
`timescale 1ns/1ps

// Operation
// RULE1: go bit with select 00 in run enters light idle
// RULE2: any nmi or unmasked maskable request leaves light idle, any priority
// RULE3: requests blocked by the three mask bits never wake
// RULE4: filtered pin three with slow sampling clock never wakes
// RULE5: lower priority wake in handler exits without ack, stays pending
// RULE6: higher priority or nmi wake exits and is acknowledged
// RULE7: nmi branches; maskable branches only when enabled, else next instruction
// RULE8: reset in idle does the ordinary reset sequence
// RULE9: light idle stops cpu, intc, timers p and q; pll runs
// RULE10: timer m runs in idle only on internal oscillator /8 or used subclock
// RULE11: watch timer runs on main divider or subclock; wdt and keys run
// RULE12: csi only on external clock; uart0 only on external clock
// RULE13: a/d converter holds in idle, result kept
// RULE14: ports, cpu state and ram kept through light idle
// RULE15: go bit with select 10 in run enters deep idle
// RULE16: deep idle also gates pll and flash; oscillator runs
// RULE17: deep idle exit waits a pll and flash setup time
// RULE18: software runs five nops after the entry write
// RULE19: pending unmasked request at entry releases deep idle at once
// RULE20: deep idle released by nmi, pins 0-7, peripherals, any reset source
// RULE21: pll restored and normal run resumes after deep idle
// RULE22: gating glitch free; idle held until a qualifying wake or reset
module sic_top (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous wake and reset pins
  input wire logic nmi_pin,
  input wire logic watchdog_nmi_request,
  input wire logic [sic_pkg::EXT_IRQ_N-1:0] ext_irq_pin,
  input wire logic [sic_pkg::RST_SRC_N-1:0] reset_source,
  // interrupt controller, same clock
  input wire logic [sic_pkg::EXT_IRQ_N-1:0] ext_irq_unmasked,
  input wire logic periph_irq_pending,
  input wire logic req_above_service,
  input wire logic cpu_irq_enabled,
  // clock gates, hold controls, reset request and resume outcome
  output sic_pkg::sic_gate_t gate_en,
  output logic adc_hold,
  output logic port_hold,
  output logic ordinary_reset,
  output sic_pkg::sic_resume_t resume
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 2 + sic_pkg::EXT_IRQ_N + sic_pkg::RST_SRC_N;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;

  // two flops on every pin before any logic
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {nmi_pin, watchdog_nmi_request, ext_irq_pin, reset_source};
      sync2_ff <= sync1_ff;
    end
  end

  // split the synchronised word back into its sources
  logic nmi_s;
  logic wdt_nmi_s;
  logic [sic_pkg::EXT_IRQ_N-1:0] ext_s;
  logic [sic_pkg::RST_SRC_N-1:0] rst_src_s;
  assign {nmi_s, wdt_nmi_s, ext_s, rst_src_s} = sync2_ff;

  // any reset source resets the controller like srst, once through the synchronisers
  logic any_rst;
  assign any_rst = srst | (|rst_src_s); // [RULE8] [RULE20]

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // software visible control state
  logic [1:0] save_mode_sel_ff;
  logic maskable_irq_mask_ff;
  logic pin_nmi_mask_ff;
  logic wdt_nmi_mask_ff;
  logic [sic_pkg::FILT_SEL_W:0] noise_filter_ctrl_ff;
  logic [sic_pkg::CS_W-1:0] clk_sel_ff;
  logic go_pulse_ff;
  sic_pkg::sic_state_t state_ff;
  sic_pkg::sic_state_t nxt_state;
  logic [3:0] wake_cause_ff;

  // apb phase decode; a write lands on the access edge
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic addr_ok;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & pready;
  assign wr_en = access_ph & pwrite & ~pslverr;
  assign addr_ok = (paddr == sic_pkg::ADDR_MODE) | (paddr == sic_pkg::ADDR_CTRL) |
                   (paddr == sic_pkg::ADDR_FILTER) | (paddr == sic_pkg::ADDR_CLKSEL) |
                   (paddr == sic_pkg::ADDR_STATUS);

  // read mux, sampled in the setup cycle
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (paddr)
      sic_pkg::ADDR_MODE: rd_val[1:0] = save_mode_sel_ff;
      sic_pkg::ADDR_CTRL: begin
        rd_val[sic_pkg::CTRL_IRQ_MASK] = maskable_irq_mask_ff;
        rd_val[sic_pkg::CTRL_PIN_NMI_MASK] = pin_nmi_mask_ff;
        rd_val[sic_pkg::CTRL_WDT_NMI_MASK] = wdt_nmi_mask_ff;
      end
      sic_pkg::ADDR_FILTER: rd_val[sic_pkg::FILT_SEL_W:0] = noise_filter_ctrl_ff;
      sic_pkg::ADDR_CLKSEL: rd_val[sic_pkg::CS_W-1:0] = clk_sel_ff;
      sic_pkg::ADDR_STATUS: rd_val[6:0] = {wake_cause_ff, state_ff};
      default: rd_val = '0;
    endcase
  end

  // apb answer: one wait-free access cycle, error on unmapped address
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~addr_ok;
      if (setup_ph) begin
        prdata <= pwrite ? '0 : rd_val;
      end
    end
  end

  // control register writes
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      save_mode_sel_ff <= sic_pkg::SMODE_LIGHT;
      maskable_irq_mask_ff <= 1'b0;
      pin_nmi_mask_ff <= 1'b0;
      wdt_nmi_mask_ff <= 1'b0;
      noise_filter_ctrl_ff <= '0;
      clk_sel_ff <= '0;
    end else if (wr_en) begin
      case (paddr)
        sic_pkg::ADDR_MODE: save_mode_sel_ff <= pwdata[1:0];
        sic_pkg::ADDR_CTRL: begin
          maskable_irq_mask_ff <= pwdata[sic_pkg::CTRL_IRQ_MASK];
          pin_nmi_mask_ff <= pwdata[sic_pkg::CTRL_PIN_NMI_MASK];
          wdt_nmi_mask_ff <= pwdata[sic_pkg::CTRL_WDT_NMI_MASK];
        end
        sic_pkg::ADDR_FILTER: noise_filter_ctrl_ff <= pwdata[sic_pkg::FILT_SEL_W:0];
        sic_pkg::ADDR_CLKSEL: clk_sel_ff <= pwdata[sic_pkg::CS_W-1:0];
        default: ;
      endcase
    end
  end

  // go bit is write-only and self clearing
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      go_pulse_ff <= 1'b0;
    end else begin
      go_pulse_ff <= wr_en & (paddr == sic_pkg::ADDR_CTRL) & pwdata[sic_pkg::CTRL_GO];
    end
  end

  // ----------------------------------------
  // wake qualification
  // ----------------------------------------
  // qualified wake sources
  logic pin3_blocked;
  logic [sic_pkg::EXT_IRQ_N-1:0] ext_valid;
  logic nmi_wake;
  logic mask_wake;
  logic wake;

  // slow digital filter on pin three cannot release idle
  assign pin3_blocked = noise_filter_ctrl_ff[sic_pkg::FILT_EN] &
    (noise_filter_ctrl_ff[sic_pkg::FILT_SEL_W:sic_pkg::FILT_SEL_LO] >=
     sic_pkg::FILT_SLOW_MIN); // [RULE4]

  always_comb begin
    ext_valid = ext_s & ext_irq_unmasked; // [RULE20]
    ext_valid[sic_pkg::EXT_IRQ_THREE] = ext_valid[sic_pkg::EXT_IRQ_THREE] & ~pin3_blocked; // [RULE4]
  end

  // masked sources are invalid and never wake
  assign nmi_wake = (nmi_s & ~pin_nmi_mask_ff) | (wdt_nmi_s & ~wdt_nmi_mask_ff); // [RULE3]
  assign mask_wake = ~maskable_irq_mask_ff & ((|ext_valid) | periph_irq_pending); // [RULE3]
  // priority does not gate the release itself
  assign wake = nmi_wake | mask_wake; // [RULE2] [RULE20]

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // counter width and last count of the deep idle setup wait
  localparam int SETUP_CNT_W_L = sic_pkg::SETUP_CNT_W;
  localparam logic [SETUP_CNT_W_L-1:0] SETUP_LAST = SETUP_CNT_W_L'(sic_pkg::DEEP_SETUP_CYC - 1);
  logic [SETUP_CNT_W_L-1:0] setup_cnt_ff;
  logic nmi_cause_ff;

  // next state of the idle sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sic_pkg::SIC_RUN: begin
        if (go_pulse_ff && save_mode_sel_ff == sic_pkg::SMODE_LIGHT) begin
          nxt_state = sic_pkg::SIC_LIGHT; // [RULE1]
        end else if (go_pulse_ff && save_mode_sel_ff == sic_pkg::SMODE_DEEP) begin
          nxt_state = sic_pkg::SIC_DEEP; // [RULE15]
        end
      end
      // stay until a qualifying wake; a pending one leaves next cycle
      sic_pkg::SIC_LIGHT: if (wake) nxt_state = sic_pkg::SIC_RESUME; // [RULE22] [RULE2]
      sic_pkg::SIC_DEEP: if (wake) nxt_state = sic_pkg::SIC_SETUP; // [RULE19] [RULE22]
      sic_pkg::SIC_SETUP: if (setup_cnt_ff == SETUP_LAST) nxt_state = sic_pkg::SIC_RESUME; // [RULE17]
      sic_pkg::SIC_RESUME: nxt_state = sic_pkg::SIC_RUN; // [RULE21]
      default: nxt_state = sic_pkg::SIC_RUN;
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      state_ff <= sic_pkg::SIC_RUN; // [RULE8]
    end else begin
      state_ff <= nxt_state;
    end
  end

  // setup timer for pll and flash recovery
  always_ff @(posedge mclk) begin
    if (any_rst || state_ff != sic_pkg::SIC_SETUP) begin
      setup_cnt_ff <= '0;
    end else begin
      setup_cnt_ff <= setup_cnt_ff + 1'b1; // [RULE17]
    end
  end

  // latch the wake source at release
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      nmi_cause_ff <= 1'b0;
      wake_cause_ff <= '0;
    end else if ((state_ff == sic_pkg::SIC_LIGHT || state_ff == sic_pkg::SIC_DEEP) && wake) begin
      nmi_cause_ff <= nmi_wake;
      wake_cause_ff <= {|ext_valid, periph_irq_pending, wdt_nmi_s, nmi_s};
    end
  end

  // ----------------------------------------
  // resume outcome to the cpu
  // ----------------------------------------
  // acknowledge a non-maskable cause or one that outranks service
  logic do_ack;
  assign do_ack = nmi_cause_ff | req_above_service; // [RULE6]

  always_ff @(posedge mclk) begin
    if (any_rst) begin
      resume <= '0;
    end else if (state_ff == sic_pkg::SIC_RESUME) begin
      resume.valid <= 1'b1;
      resume.ack <= do_ack; // [RULE6]
      resume.keep_pending <= ~do_ack; // [RULE5]
      resume.branch <= nmi_cause_ff | (cpu_irq_enabled & req_above_service); // [RULE7]
      resume.next_insn <= ~nmi_cause_ff & ~(cpu_irq_enabled & req_above_service); // [RULE7]
    end else begin
      resume <= '0;
    end
  end

  // ----------------------------------------
  // clock gates
  // ----------------------------------------
  // gate decisions follow the next state so they land with it
  logic idle;
  logic deep;
  sic_pkg::sic_gate_t nxt_gate;
  assign idle = (nxt_state == sic_pkg::SIC_LIGHT) | (nxt_state == sic_pkg::SIC_DEEP) |
                (nxt_state == sic_pkg::SIC_SETUP);
  assign deep = (nxt_state == sic_pkg::SIC_DEEP) | (nxt_state == sic_pkg::SIC_SETUP);

  always_comb begin
    nxt_gate.cpu = ~idle; // [RULE9]
    nxt_gate.intc = ~idle; // [RULE9]
    nxt_gate.tmr_pq = ~idle; // [RULE9]
    nxt_gate.pll = ~deep | (nxt_state == sic_pkg::SIC_SETUP); // [RULE16] [RULE21]
    nxt_gate.flash = ~deep | (nxt_state == sic_pkg::SIC_SETUP); // [RULE16]
    nxt_gate.tmm = ~idle | clk_sel_ff[sic_pkg::CS_TMM_FR8] |
      (clk_sel_ff[sic_pkg::CS_SUB_USED] & clk_sel_ff[sic_pkg::CS_TMM_SUB]); // [RULE10]
    nxt_gate.watch = ~idle | clk_sel_ff[sic_pkg::CS_WT_MAIN] |
      clk_sel_ff[sic_pkg::CS_SUB_USED]; // [RULE11]
    nxt_gate.wdt = 1'b1; // [RULE11]
    nxt_gate.key = 1'b1; // [RULE11]
    nxt_gate.csi0 = ~idle | clk_sel_ff[sic_pkg::CS_CSI0_EXT]; // [RULE12]
    nxt_gate.csi1 = ~idle | clk_sel_ff[sic_pkg::CS_CSI1_EXT]; // [RULE12]
    nxt_gate.uart0 = ~idle | clk_sel_ff[sic_pkg::CS_UART0_EXT]; // [RULE12]
    nxt_gate.uart1 = ~idle; // [RULE12]
  end

  // registered enables so the gate cells see clean levels
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      gate_en <= '1;
    end else begin
      gate_en <= nxt_gate; // [RULE22]
    end
  end

  // hold controls keep ports and converter result
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      adc_hold <= 1'b0;
      port_hold <= 1'b0;
    end else begin
      adc_hold <= idle; // [RULE13]
      port_hold <= idle; // [RULE14]
    end
  end

  // ordinary reset request while any source is active
  always_ff @(posedge mclk) begin
    if (srst) begin
      ordinary_reset <= 1'b0;
    end else begin
      ordinary_reset <= |rst_src_s; // [RULE8]
    end
  end

endmodule

// [hw/sic_pkg.sv]
// sic_pkg: constants and carrier types of the standby idle controller
// assumes a 40 MHz mclk and an apb master with 32-bit data
package sic_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  // pll and flash recovery time after deep idle, in ns
  localparam int DEEP_SETUP_NS = 1000;
  localparam int DEEP_SETUP_CYC_RAW = (DEEP_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DEEP_SETUP_CYC = (DEEP_SETUP_CYC_RAW < 1) ? 1 : DEEP_SETUP_CYC_RAW;
  localparam int SETUP_CNT_W = 8;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_FILTER = 8'h08;
  localparam logic [7:0] ADDR_CLKSEL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // save-mode select codes
  localparam logic [1:0] SMODE_LIGHT = 2'h0;
  localparam logic [1:0] SMODE_DEEP = 2'h2;

  // power_save_ctrl bit positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_IRQ_MASK = 1;
  localparam int CTRL_PIN_NMI_MASK = 2;
  localparam int CTRL_WDT_NMI_MASK = 3;

  // noise_filter_ctrl fields
  localparam int FILT_EN = 0;
  localparam int FILT_SEL_LO = 1;
  localparam int FILT_SEL_W = 3;
  // sampling selects from the divide-by-64 clock upward
  localparam logic [2:0] FILT_SLOW_MIN = 3'h3;

  // clock select bit positions
  localparam int CS_SUB_USED = 0;
  localparam int CS_TMM_FR8 = 1;
  localparam int CS_TMM_SUB = 2;
  localparam int CS_WT_MAIN = 3;
  localparam int CS_CSI0_EXT = 4;
  localparam int CS_CSI1_EXT = 5;
  localparam int CS_UART0_EXT = 6;
  localparam int CS_W = 7;

  localparam int EXT_IRQ_N = 8;
  localparam int EXT_IRQ_THREE = 3;
  localparam int RST_SRC_N = 5;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SIC_RUN,
    SIC_LIGHT,
    SIC_DEEP,
    SIC_SETUP,
    SIC_RESUME
  } sic_state_t;

  // clock gate enables, one per domain
  typedef struct packed {
    logic cpu;
    logic intc;
    logic tmr_pq;
    logic pll;
    logic flash;
    logic tmm;
    logic watch;
    logic wdt;
    logic key;
    logic csi0;
    logic csi1;
    logic uart0;
    logic uart1;
  } sic_gate_t;

  // wake outcome handed to the cpu core
  typedef struct packed {
    logic valid;
    logic ack;
    logic keep_pending;
    logic branch;
    logic next_insn;
  } sic_resume_t;
endpackage

// [test/sic_top_asserts.sv]
// sic_top_asserts: port-level checks of the standby idle controller
// assumes sic_pkg is compiled first; bound onto sic_top below
`timescale 1ns/1ps
module sic_top_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // wake and reset sources
  input wire logic nmi_pin,
  input wire logic watchdog_nmi_request,
  input wire logic [sic_pkg::EXT_IRQ_N-1:0] ext_irq_pin,
  input wire logic [sic_pkg::RST_SRC_N-1:0] reset_source,
  input wire logic periph_irq_pending,
  // controller outputs
  input wire sic_pkg::sic_gate_t gate_en,
  input wire logic adc_hold,
  input wire logic port_hold,
  input wire logic ordinary_reset,
  input wire sic_pkg::sic_resume_t resume
);
  localparam int SET_LO = 30;
  localparam int SET_HI = 38;
  logic quiet;
  // no wake or reset source asking
  assign quiet = !nmi_pin && !watchdog_nmi_request && (ext_irq_pin == '0)
    && !periph_irq_pending && (reset_source == '0);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no pready in access cycle");
  idle_stop_a: assert property (!gate_en.intc |-> !gate_en.cpu && !gate_en.tmr_pq)
    else $error("cpu or timers run while intc is gated");
  always_run_a: assert property (gate_en.wdt && gate_en.key)
    else $error("watchdog or key clock gated");
  idle_hold_a: assert property ($fell(gate_en.cpu) |-> adc_hold && port_hold)
    else $error("holds not set at idle entry");
  deep_gate_a: assert property (!gate_en.pll |-> !gate_en.flash && !gate_en.cpu)
    else $error("flash or cpu clocked in deep idle");
  deep_setup_a: assert property ($rose(gate_en.pll) && !ordinary_reset |->
    (!resume.valid)[*8] ##[SET_LO:SET_HI] resume.valid)
    else $error("deep idle setup time wrong");
  deep_held_a: assert property ((!gate_en.pll && quiet)[*4] |=> !gate_en.pll)
    else $error("deep idle left without wake");
  ack_keep_a: assert property (resume.valid |-> resume.ack != resume.keep_pending)
    else $error("ack and keep pending not exclusive");
  nmi_branch_a: assert property (resume.valid && nmi_pin |-> resume.branch && resume.ack)
    else $error("nmi wake did not branch");
  reset_seq_a: assert property ($rose(|reset_source) |-> ##[2:4] ordinary_reset)
    else $error("reset source not turned into reset");
  reset_gates_a: assert property (ordinary_reset |-> gate_en == 13'h1FFF && !resume.valid)
    else $error("gates not open during reset");
  // main scenarios reached
  cover property (resume.valid && resume.ack);
  cover property (resume.valid && resume.keep_pending);
  cover property ($fell(gate_en.pll));
  cover property (ordinary_reset);
endmodule

bind sic_top sic_top_asserts u_sic_top_asserts (.mclk(mclk), .srst(srst), .psel(psel),
  .penable(penable), .pready(pready), .nmi_pin(nmi_pin),
  .watchdog_nmi_request(watchdog_nmi_request), .ext_irq_pin(ext_irq_pin),
  .reset_source(reset_source), .periph_irq_pending(periph_irq_pending), .gate_en(gate_en),
  .adc_hold(adc_hold), .port_hold(port_hold), .ordinary_reset(ordinary_reset),
  .resume(resume));

// [test/sic_wake_model.sv]
// sic_wake_model: interrupt side that raises wake requests
// assumes the bench selects sources; resume comes from sic_top
`timescale 1ns/1ps
module sic_wake_model (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // bench selection {nmi, wdt nmi, pins 7..0, peripheral}
  input wire logic [10:0] req_sel,
  input wire sic_pkg::sic_resume_t resume,
  // wake requests
  output logic nmi_pin,
  output logic watchdog_nmi_request,
  output logic [sic_pkg::EXT_IRQ_N-1:0] ext_irq_pin,
  output logic periph_irq_pending
);
  logic taken_ff;
  // an acknowledged request is withdrawn until the bench clears it
  always_ff @(posedge mclk) begin
    if (srst || req_sel == 11'h000) begin
      taken_ff <= 1'b0;
    end else if (resume.valid && resume.ack) begin
      taken_ff <= 1'b1;
    end
  end
  // a request left unacknowledged stays pending at its level
  assign {nmi_pin, watchdog_nmi_request, ext_irq_pin, periph_irq_pending} =
    taken_ff ? 11'h000 : req_sel;
endmodule

// [test/standby_idle_mode_control_tb.sv]
// standby_idle_mode_control_tb: self-checking bench of the idle sequencer
// assumes sic_pkg, sic_top, the checker and sic_wake_model compiled first
`timescale 1ns/1ps
module standby_idle_mode_control_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] unmasked = 8'hFF;
  logic [4:0] rst_src = 5'h00;
  logic above = 1'b0;
  logic ei = 1'b0;
  logic [10:0] req_sel = 11'h000;
  logic [31:0] prdata;
  logic pready, pslverr, nmi_pin, wdt_nmi, periph, adc_hold, port_hold, ord_rst, er;
  logic [7:0] ext_pin;
  logic [31:0] rd;
  sic_pkg::sic_gate_t gate_en;
  sic_pkg::sic_resume_t resume;
  int n_errors = 0;
  int n_compared = 0;
  int cyc;
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  sic_top u_sic_top (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_pin(nmi_pin), .watchdog_nmi_request(wdt_nmi), .ext_irq_pin(ext_pin),
    .reset_source(rst_src), .ext_irq_unmasked(unmasked), .periph_irq_pending(periph),
    .req_above_service(above), .cpu_irq_enabled(ei), .gate_en(gate_en), .adc_hold(adc_hold),
    .port_hold(port_hold), .ordinary_reset(ord_rst), .resume(resume));
  sic_wake_model u_sic_wake_model (.mclk(mclk), .srst(srst), .req_sel(req_sel),
    .resume(resume), .nmi_pin(nmi_pin), .watchdog_nmi_request(wdt_nmi),
    .ext_irq_pin(ext_pin), .periph_irq_pending(periph));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [1:0] mode, input logic [31:0] ctrl);
    apb(1'b1, sic_pkg::ADDR_MODE, 32'(mode));
    apb(1'b1, sic_pkg::ADDR_CTRL, ctrl | 32'h1);
    repeat (5) @(posedge mclk); // five no-op cycles
  endtask
  task automatic wait_wake;
    cyc = 0;
    while (resume.valid !== 1'b1 && cyc < 100) begin
      @(posedge mclk);
      cyc++;
    end
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(1'b1, sic_pkg::ADDR_STATUS, 32'hFF);
    apb(1'b0, sic_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0, "status read only");
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    chk(32'(er), 32'h1, "unmapped write");
    go(2'h1, 32'h0);
    chk(32'(gate_en), 32'h1FFF, "select 01 ignored");
    apb(1'b0, sic_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0, "go reads zero");
  endtask
  task automatic t_wake(input logic [1:0] mode, input logic [12:0] gexp, input int lo,
    input int hi);
    logic [10:0] src [5] = '{11'h100, 11'h400, 11'h200, 11'h001, 11'h002};
    logic [1:0] ab [5] = '{2'b01, 2'b00, 2'b01, 2'b11, 2'b10};
    logic [4:0] rexp [5] = '{5'h15, 5'h1A, 5'h1A, 5'h1A, 5'h19};
    for (int i = 0; i < 5; i++) begin
      go(mode, 32'h0);
      chk(32'(gate_en), 32'(gexp), "idle gates");
      chk(32'({adc_hold, port_hold}), 32'h3, "holds");
      {above, ei} <= ab[i];
      req_sel <= src[i];
      wait_wake;
      chk(32'(resume), 32'(rexp[i]), "resume");
      chk(32'(cyc >= lo && cyc <= hi), 32'h1, "wake delay");
      req_sel <= 11'h000;
      repeat (3) @(posedge mclk);
      chk(32'(gate_en), 32'h1FFF, "run gates");
      chk(32'({adc_hold, port_hold}), 32'h0, "holds released");
      chk(32'(resume), 32'h0, "resume one cycle");
    end
  endtask
  task automatic t_pend;
    {above, ei} <= 2'b11;
    req_sel <= 11'h001;
    go(sic_pkg::SMODE_DEEP, 32'h0);
    wait_wake;
    chk(32'(resume), 32'h1A, "pending wake");
    req_sel <= 11'h000;
  endtask
  task automatic t_mask;
    go(sic_pkg::SMODE_LIGHT, 32'hE);
    req_sel <= 11'h7FF;
    repeat (20) @(posedge mclk);
    chk(32'(gate_en), 32'h0330, "masked stays idle");
    rst_src <= 5'h02;
    repeat (6) @(posedge mclk);
    chk(32'({ord_rst, gate_en}), 32'h3FFF, "reset in idle");
    rst_src <= 5'h00;
    req_sel <= 11'h000;
    repeat (6) @(posedge mclk);
    apb(1'b0, sic_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0, "masks cleared");
    apb(1'b1, sic_pkg::ADDR_FILTER, 32'h7);
    go(sic_pkg::SMODE_LIGHT, 32'hC);
    req_sel <= 11'h010;
    repeat (20) @(posedge mclk);
    chk(32'(gate_en), 32'h0330, "filtered pin stays idle");
    {above, ei} <= 2'b10;
    req_sel <= 11'h012;
    wait_wake;
    chk(32'(resume), 32'h19, "pin zero wake");
    req_sel <= 11'h000;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    t_regs;
    apb(1'b1, sic_pkg::ADDR_CLKSEL, 32'h7F);
    t_wake(sic_pkg::SMODE_LIGHT, 13'h03FE, 2, 10);
    apb(1'b1, sic_pkg::ADDR_CLKSEL, 32'h0);
    t_wake(sic_pkg::SMODE_DEEP, 13'h0030, 40, 60);
    t_pend;
    t_mask;
    conclude;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    conclude;
  end
endmodule
